// *** rtl/aprfp_pkg.sv ***
// Purpose: Shared constants and types of the request frame parser.
// Assumes: One 20 MHz device clock; APB register access.
// Notes:   Frame offsets count from the start delimiter at offset 0.
package aprfp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0]  START_BYTE   = 8'h7e;
  localparam logic [7:0]  ESC_BYTE     = 8'h7d;
  localparam logic [7:0]  ESC_XOR      = 8'h20;
  localparam logic [7:0]  CSUM_GOOD    = 8'hff;
  localparam logic [7:0]  TYPE_IMM     = 8'h08;
  localparam logic [7:0]  TYPE_QUE     = 8'h09;
  localparam logic [7:0]  TYPE_TX      = 8'h00;
  localparam logic [7:0]  RESP_AT      = 8'h88;
  localparam logic [7:0]  RESP_TX      = 8'h89;
  localparam logic [15:0] APPLY_CMD    = 16'h4143;
  localparam logic [63:0] BCAST_ADDR   = 64'h0000_0000_0000_ffff;
  localparam int          OPT_NOACK    = 0;
  localparam int          OPT_PAN      = 2;

  localparam logic [16:0] OFS_TYPE     = 17'h0_0003;
  localparam logic [16:0] OFS_ID       = 17'h0_0004;
  localparam logic [16:0] OFS_CMD      = 17'h0_0005;
  localparam logic [16:0] OFS_VAL      = 17'h0_0007;
  localparam logic [16:0] OFS_DEST     = 17'h0_0005;
  localparam logic [16:0] OFS_OPT      = 17'h0_000d;
  localparam logic [16:0] LAST_BIAS    = 17'h0_0002;
  localparam logic [15:0] MIN_CMD_LEN  = 16'h0004;
  localparam logic [15:0] MIN_TX_LEN   = 16'h000b;
  localparam logic [7:0]  VAL_BYTES    = 8'h04;

  localparam int          PARAM_AW     = 4;
  localparam int          PARAM_DEPTH  = 16;
  localparam logic [4:0]  SWEEP_END    = 5'h10;

  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_ERRCNT   = 8'h08;
  localparam logic [7:0]  REG_FRMCNT   = 8'h0c;
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam int          CTRL_ESC     = 0;
  localparam int          CTRL_ALTFW   = 1;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } aprfp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } aprfp_apb_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  rtype;
    logic [7:0]  id;
    logic        ok;
    logic [31:0] value;
  } aprfp_resp_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] dest;
    logic        broadcast;
    logic        no_ack;
    logic        bcast_pan;
    logic [15:0] len;
  } aprfp_tx_t;

  // Parameter slot chosen from the two command characters.
  function automatic logic [PARAM_AW-1:0] aprfp_slot(input logic [15:0] c);
    return c[11:8] ^ c[3:0];
  endfunction

endpackage

// *** rtl/aprfp_param_mem.sv ***
// Purpose: Small parameter store, one write port, registered read data.
// Assumes: Same clock and clock enable as the parser.
// Notes:   Read data appear one enabled edge after the address.
`timescale 1ns/1ns
module aprfp_param_mem
  import aprfp_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  input  wire logic                we,
  input  wire logic [PARAM_AW-1:0] waddr,
  input  wire logic [31:0]         wdata,
  input  wire logic [PARAM_AW-1:0] raddr,
  output logic      [31:0]         rdata
);

  typedef struct packed {
    logic [PARAM_DEPTH-1:0][31:0] mem;
    logic [31:0]                  rd;
  } aprfp_mem_state_t;

  aprfp_mem_state_t q;
  aprfp_mem_state_t next_q;

  always_comb begin
    next_q = q;
    next_q.rd = q.mem[raddr];
    if (we) begin
      next_q.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign rdata = q.rd;

endmodule

// *** rtl/aprfp_parser.sv ***
// Purpose: Parses host request frames and decodes command and transmit.
// Assumes: rx bytes come from a receiver on ref_clk; APB register access.
// Notes:   Payload bytes are counted, not stored.
// Behaviour
// R1: Queued set stores value as pending only.
// R2: Immediate frame or apply command commits pending.
// R3: No value means query; answer current value.
// R4: Response copies request frame identifier.
// R5: Identifier zero suppresses any response.
// R6: Delimiter, then 16-bit length of body.
// R7: Type at offset 3, identifier at 4.
// R8: Command characters at 5, value from 7.
// R9: Checksum is 0xFF minus body byte sum.
// R10: Transmit: address at 5, options 13, payload.
// R11: Broadcast address means broadcast, not unicast.
// R12: Options: no-ack, reserved, broadcast network identifier.
// R13: Host zeroes unused option bits.
// R14: Host limits payload to reported maximum.
// R15: Transmit request answered by status frame.
// R16: Queued set response reports accept or reject.
// R17: Immediate set applies now, commits pending.
// R18: Escaped byte is 0x7D then byte^0x20.
// R19: Delimiter 0x7E; discard bytes until seen.
// R20: Bad checksum frame has no effects.
`timescale 1ns/1ns
module aprfp_parser
  import aprfp_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           reset_n,
  input  wire logic           ce,
  input  wire logic           rx_valid,
  input  wire logic [7:0]     rx_byte,
  output logic                rx_ready,
  input  wire aprfp_apb_req_t apb_req,
  output aprfp_apb_rsp_t      apb_rsp,
  output aprfp_resp_t         resp,
  output aprfp_tx_t           tx,
  output logic                params_applied
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE, ST_LEN_HI, ST_LEN_LO, ST_BODY, ST_CSUM,
    ST_SWEEP, ST_QUERY, ST_QDATA
  } aprfp_fsm_t;

  typedef enum logic [0:0] {ACT_NONE, ACT_RESP} aprfp_tail_t;

  typedef struct packed {
    aprfp_fsm_t       st;
    logic             resp_due;
    logic             esc_pend;
    logic [15:0]      len;
    logic [16:0]      pos;
    logic [7:0]       sum;
    logic [7:0]       ftype;
    logic [7:0]       fid;
    logic [15:0]      cmd;
    logic [31:0]      val;
    logic [7:0]       vlen;
    logic [63:0]      dest;
    logic [7:0]       opt;
    logic [PARAM_DEPTH-1:0] pend;
    logic [4:0]       sweep;
    logic             do_query;
    logic             ok;
    logic [7:0]       rtype;
    logic [1:0]       ctrl;
    logic [15:0]      errcnt;
    logic [15:0]      frmcnt;
    logic             rx_ready;
    logic             applied;
    aprfp_apb_rsp_t   apb;
    aprfp_resp_t      resp;
    aprfp_tx_t        tx;
  } aprfp_state_t;

  aprfp_state_t        q;
  aprfp_state_t        next_q;
  logic                rx_take;
  logic [7:0]          data;
  logic                acc;
  logic                bad;
  logic [PARAM_AW-1:0] pidx;
  logic [PARAM_AW-1:0] sidx;
  logic                act_we;
  logic [PARAM_AW-1:0] act_waddr;
  logic [31:0]         act_wdata;
  logic [PARAM_AW-1:0] act_raddr;
  logic [31:0]         act_rdata;
  logic                pend_we;
  logic [31:0]         pend_rdata;
  logic                apb_acc;

  assign rx_take = rx_valid & q.rx_ready;
  assign pidx    = aprfp_slot(q.cmd);
  assign sidx    = PARAM_AW'(q.sweep - 5'h01);
  assign apb_acc = apb_req.psel & apb_req.penable & ~q.apb.pready;

  ////////////////////////////////////////////////////////////////////////////
  // Active values and staged values live in two separate stores so that a
  // staged change can never be seen by the query path before it commits.
  aprfp_param_mem u_active (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .ce      (ce),
    .we      (act_we),
    .waddr   (act_waddr),
    .wdata   (act_wdata),
    .raddr   (act_raddr),
    .rdata   (act_rdata)
  );

  aprfp_param_mem u_pending (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .ce      (ce),
    .we      (pend_we),
    .waddr   (pidx),
    .wdata   (q.val),
    .raddr   (q.sweep[PARAM_AW-1:0]),
    .rdata   (pend_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_q = q;
    next_q.resp.valid = 1'b0;
    next_q.tx.valid = 1'b0;
    next_q.applied = 1'b0;
    act_we = 1'b0;
    act_waddr = pidx;
    act_wdata = q.val;
    act_raddr = pidx;
    pend_we = 1'b0;
    acc = 1'b0;
    bad = 1'b0;
    data = q.esc_pend ? (rx_byte ^ ESC_XOR) : rx_byte; // R18
    if (rx_take) begin
      // In escaped mode a raw delimiter always restarts the frame.
      if (rx_byte == START_BYTE &&
          (q.st == ST_IDLE || q.ctrl[CTRL_ESC])) begin // R19
        next_q.st = ST_LEN_HI;
        next_q.esc_pend = 1'b0;
        next_q.sum = 8'h00;
        next_q.vlen = 8'h00;
        next_q.val = 32'h0000_0000;
      end else if (q.ctrl[CTRL_ESC] && rx_byte == ESC_BYTE &&
                   !q.esc_pend && q.st != ST_IDLE) begin
        next_q.esc_pend = 1'b1; // R18
      end else begin
        next_q.esc_pend = 1'b0;
        case (q.st)
          ST_LEN_HI: begin
            next_q.len[15:8] = data; // R6
            next_q.st = ST_LEN_LO;
          end
          ST_LEN_LO: begin
            next_q.len[7:0] = data; // R6
            next_q.pos = OFS_TYPE;
            next_q.st = ({q.len[15:8], data} == 16'h0000) ? ST_IDLE
                                                            : ST_BODY;
          end
          ST_BODY: begin
            next_q.sum = q.sum + data; // R9
            next_q.pos = q.pos + 17'h0_0001;
            if (q.pos == OFS_TYPE) begin
              next_q.ftype = data; // R7
            end
            if (q.pos == OFS_ID) begin
              next_q.fid = data; // R7
            end
            if (q.pos == OFS_CMD) begin
              next_q.cmd[15:8] = data; // R8
            end
            if (q.pos == OFS_CMD + 17'h0_0001) begin
              next_q.cmd[7:0] = data; // R8
            end
            if (q.pos >= OFS_VAL) begin
              next_q.val = {q.val[23:0], data}; // R8
              if (q.vlen != 8'hff) begin
                next_q.vlen = q.vlen + 8'h01;
              end
            end
            if (q.pos >= OFS_DEST && q.pos < OFS_OPT) begin
              next_q.dest = {q.dest[55:0], data}; // R10
            end
            if (q.pos == OFS_OPT) begin
              next_q.opt = data; // R10
            end
            if (q.pos == {1'b0, q.len} + LAST_BIAS) begin
              next_q.st = ST_CSUM;
            end
          end
          ST_CSUM: begin
            next_q.st = ST_IDLE;
            if (8'(q.sum + data) == CSUM_GOOD) begin // R9
              acc = 1'b1;
            end else begin
              bad = 1'b1; // R20
            end
          end
          default: begin
            next_q.st = ST_IDLE; // R19
          end
        endcase
      end
    end

    if (bad) begin
      next_q.errcnt = q.errcnt + 16'h0001;
    end
    if (acc) begin
      next_q.frmcnt = q.frmcnt + 16'h0001;
      next_q.sweep = 5'h00;
      next_q.resp_due = (q.fid != 8'h00); // R5
      case (q.ftype)
        TYPE_QUE, TYPE_IMM: begin
          if (q.len >= MIN_CMD_LEN) begin
            next_q.rtype = RESP_AT;
            next_q.do_query = (q.vlen == 8'h00) && (q.cmd != APPLY_CMD);
            next_q.ok = (q.vlen <= VAL_BYTES); // R16
            if (q.vlen != 8'h00 && q.vlen <= VAL_BYTES &&
                q.cmd != APPLY_CMD) begin
              if (q.ftype == TYPE_QUE) begin
                pend_we = 1'b1; // R1
                next_q.pend[pidx] = 1'b1; // R1
              end else begin
                act_we = 1'b1; // R17
                next_q.pend[pidx] = 1'b0; // R17
              end
            end
            if (q.ftype == TYPE_IMM || q.cmd == APPLY_CMD) begin
              next_q.st = ST_SWEEP; // R2
            end else if (q.vlen == 8'h00) begin
              next_q.st = ST_QUERY; // R3
            end else begin
              next_q.st = ST_QDATA;
            end
          end
        end
        TYPE_TX: begin
          if (q.len >= MIN_TX_LEN) begin
            next_q.tx.valid = 1'b1;
            next_q.tx.dest = q.dest;
            next_q.tx.broadcast = (q.dest == BCAST_ADDR); // R11
            next_q.tx.no_ack = q.opt[OPT_NOACK]; // R12
            next_q.tx.bcast_pan = q.opt[OPT_PAN] & q.ctrl[CTRL_ALTFW]; // R12
            next_q.tx.len = q.len - MIN_TX_LEN; // R10
            next_q.rtype = RESP_TX; // R15
            next_q.ok = 1'b1;
            next_q.do_query = 1'b0;
            next_q.st = ST_QDATA;
          end
        end
        default: begin
          next_q.resp_due = 1'b0;
        end
      endcase
    end

    case (q.st)
      ST_SWEEP: begin
        if (q.sweep != 5'h00 && q.pend[sidx]) begin
          act_we = 1'b1; // R2
          act_waddr = sidx;
          act_wdata = pend_rdata;
          next_q.pend[sidx] = 1'b0;
        end
        if (q.sweep == SWEEP_END) begin
          next_q.applied = 1'b1;
          next_q.st = q.do_query ? ST_QUERY : ST_QDATA;
        end else begin
          next_q.sweep = q.sweep + 5'h01;
        end
      end
      ST_QUERY: begin
        next_q.do_query = 1'b1;
        next_q.st = ST_QDATA;
      end
      ST_QDATA: begin
        if (q.do_query) begin
          next_q.val = act_rdata; // R3
        end
        next_q.do_query = 1'b0;
        next_q.st = q.do_query ? ST_QDATA : ST_IDLE;
        if (!q.do_query && q.resp_due) begin
          next_q.resp = {1'b1, q.rtype, q.fid, q.ok, q.val}; // R4
        end
      end
      default: begin
      end
    endcase

    next_q.rx_ready = (next_q.st <= ST_CSUM);

    // A write lands at the edge where the master sees pready, not earlier.
    if (apb_req.psel && apb_req.penable && q.apb.pready &&
        apb_req.pwrite && apb_req.paddr == REG_CTRL) begin
      next_q.ctrl = apb_req.pwdata[1:0];
    end
    next_q.apb.pready = apb_acc;
    next_q.apb.pslverr = 1'b0;
    next_q.apb.prdata = 32'h0000_0000;
    if (apb_acc) begin
      case (apb_req.paddr)
        REG_CTRL: begin
          next_q.apb.prdata = {30'h0000_0000, q.ctrl};
        end
        REG_STATUS: begin
          next_q.apb.prdata = {q.pend, 15'h0000, q.st != ST_IDLE};
        end
        REG_ERRCNT: begin
          next_q.apb.prdata = {16'h0000, q.errcnt};
        end
        REG_FRMCNT: begin
          next_q.apb.prdata = {16'h0000, q.frmcnt};
        end
        default: begin
          next_q.apb.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign rx_ready       = q.rx_ready;
  assign apb_rsp        = q.apb;
  assign resp           = q.resp;
  assign tx             = q.tx;
  assign params_applied = q.applied;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk iff ce); endclocking
  default disable iff (!reset_n);

  sequence s_acc_cmd;
    acc && (q.ftype == TYPE_IMM || q.ftype == TYPE_QUE) &&
    q.len >= MIN_CMD_LEN;
  endsequence

  sequence s_sweep_done;
    q.st == ST_SWEEP && q.sweep == SWEEP_END;
  endsequence

  AST_QUEUE_NO_APPLY: assert property ( // R1
    s_acc_cmd and (q.ftype == TYPE_QUE && q.cmd != APPLY_CMD)
    |=> q.st != ST_SWEEP && !params_applied)
    else $error("queued set reached the active store");

  AST_IMM_COMMITS: assert property ( // R2
    s_acc_cmd and (q.ftype == TYPE_IMM)
    |=> q.st == ST_SWEEP ##16 s_sweep_done ##1 params_applied)
    else $error("immediate frame did not commit pending values");

  AST_QUERY_ANSWERS: assert property ( // R3
    s_acc_cmd and (q.ftype == TYPE_QUE && q.vlen == 8'h00 &&
    q.cmd != APPLY_CMD && q.fid != 8'h00)
    |=> ##3 resp.valid && resp.rtype == RESP_AT)
    else $error("query produced no response");

  AST_RESP_ID: assert property ( // R4
    resp.valid |-> resp.id == $past(q.fid))
    else $error("response identifier differs from request");

  AST_ZERO_ID_QUIET: assert property ( // R5
    acc && q.fid == 8'h00 |=> !resp.valid [*8])
    else $error("response sent for identifier zero");

  AST_BAD_CSUM: assert property ( // R20
    bad |=> q.st == ST_IDLE && q.pend == $past(q.pend) && !resp.valid)
    else $error("bad checksum frame had an effect");

  AST_BCAST: assert property ( // R11
    tx.valid |-> tx.broadcast == (tx.dest == BCAST_ADDR))
    else $error("broadcast decode wrong");

  AST_PAN_OPT: assert property ( // R12
    tx.valid && !q.ctrl[CTRL_ALTFW] |-> !tx.bcast_pan)
    else $error("network identifier option outside alternate firmware");

  AST_TX_STATUS: assert property ( // R15
    tx.valid && q.fid != 8'h00 |=> resp.valid && resp.rtype == RESP_TX)
    else $error("transmit request not acknowledged");

  AST_SWEEP_CLEARS: assert property ( // R2
    s_sweep_done |=> q.pend == '0)
    else $error("pending flags left after commit");

endmodule

// *** dv/aprfp_host_model.sv ***
// Purpose: Host side of the serial request link, one byte per handshake.
// Assumes: Bytes handed over on ref_clk with the valid/ready handshake.
// Notes:   Length and checksum are made over the unescaped body.
`timescale 1ns/1ns
module aprfp_host_model
  import aprfp_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rx_ready,
  input  wire logic esc_on,
  output logic      rx_valid,
  output logic [7:0] rx_byte
);
  // Handshakes that never saw ready; the bench adds them to its fails count.
  int stalls = 0;

  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // A released line shows the inverse, so a stale byte is never reused.
  task automatic put(input logic [7:0] b, input int gap);
    int i;
    rx_valid <= 1'b1;
    rx_byte  <= b;
    for (i = 0; i < 400; i++) begin
      @(negedge ref_clk);
      if (rx_ready === 1'b1) break;
    end
    if (i == 400) stalls++;
    @(posedge ref_clk);
    if (gap > 0) begin
      rx_valid <= 1'b0;
      rx_byte  <= ~b;
      repeat (gap) @(posedge ref_clk);
    end
  endtask

  task automatic eput(input logic [7:0] b, input int gap);
    if (esc_on && (b == START_BYTE || b == ESC_BYTE)) begin
      put(ESC_BYTE, 0);
      put(b ^ ESC_XOR, gap);
    end else begin
      put(b, gap);
    end
  endtask

  task automatic send(input logic [7:0] body[$], input logic bad,
                      input int gap);
    logic [7:0]  s;
    logic [15:0] n;
    s = 8'h00;
    n = 16'(body.size());
    foreach (body[i]) s += body[i];
    s = CSUM_GOOD - s;
    if (bad) s = ~s;
    put(START_BYTE, gap);
    eput(n[15:8], gap);
    eput(n[7:0], gap);
    foreach (body[i]) eput(body[i], gap);
    eput(s, 1);
  endtask
endmodule

// *** dv/api_request_frame_parser_bench.sv ***
// Purpose: Self-checking bench of the request frame parser.
// Assumes: 20 MHz ref_clk; registers reached over APB.
// Notes:   Outputs are sampled at the falling edge, where they are settled.
`timescale 1ns/1ns
module api_request_frame_parser_bench
  import aprfp_pkg::*;
();
  logic           ref_clk = 1'b0;
  logic           reset_n = 1'b0;
  logic           ce      = 1'b1;
  logic           esc_on  = 1'b0;
  logic           rx_valid, rx_ready, params_applied;
  logic [7:0]     rx_byte;
  aprfp_apb_req_t apb_req = '0;
  aprfp_apb_rsp_t apb_rsp;
  aprfp_resp_t    resp;
  aprfp_tx_t      tx;
  aprfp_resp_t    rq[$];
  aprfp_tx_t      tq[$];
  logic [7:0]     nv[$];
  int             fails, tests_run, napp;

  always #25 ref_clk = ~ref_clk;

  aprfp_parser i_aprfp_parser (.ref_clk(ref_clk), .reset_n(reset_n),
    .ce(ce), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .resp(resp), .tx(tx),
    .params_applied(params_applied));
  aprfp_host_model i_aprfp_host_model (.ref_clk(ref_clk),
    .rx_ready(rx_ready), .esc_on(esc_on), .rx_valid(rx_valid),
    .rx_byte(rx_byte));

  always @(negedge ref_clk) begin
    if (resp.valid === 1'b1) rq.push_back(resp);
    if (tx.valid === 1'b1) tq.push_back(tx);
    if (params_applied === 1'b1) napp++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    fails += i_aprfp_host_model.stalls;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int i;
    @(posedge ref_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      if (apb_rsp.pready === 1'b1) break;
    end
    if (i == 50) begin
      fails++;
      finish_test();
    end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    @(posedge ref_clk);
    apb_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, x);
    chk(e, xe);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic idle();
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge ref_clk);
      if (rx_ready === 1'b1) break;
    end
    if (i == 300) begin
      fails++;
      finish_test();
    end
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic cmd(input logic [7:0] ty, input logic [7:0] id,
                     input logic [15:0] c, input logic [7:0] v[$],
                     input logic bad);
    logic [7:0] b[$];
    b = {ty, id, c[15:8], c[7:0]};
    b = {b, v};
    rq.delete();
    tq.delete();
    i_aprfp_host_model.send(b, bad, $urandom_range(0, 2));
    idle();
  endtask

  task automatic exp_resp(input logic [7:0] id, input logic ok,
                          input logic [31:0] v, input logic cv);
    chk(rq.size(), (id != 8'h00) ? 1 : 0);
    if (rq.size() > 0) begin
      chk(rq[0].rtype, RESP_AT);
      chk(rq[0].id, id);
      chk(rq[0].ok, ok);
      if (cv) chk(rq[0].value, v);
    end
  endtask

  // Big-endian value bytes.
  function automatic logic [31:0] fold(input logic [7:0] v[$]);
    logic [31:0] r;
    r = '0;
    foreach (v[i]) r = {r[23:0], v[i]};
    return r;
  endfunction

  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0]  vb[$], b[$], id, opt;
    logic [63:0] d;
    logic [31:0] v;
    int          n;
    v = $urandom(32'h8efb);
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(REG_CTRL, 32'h0000_0000, 1'b0);
    rd(REG_ERRCNT, 32'h0000_0000, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b1);
    wr(REG_CTRL, 32'h0000_0003);
    rd(REG_CTRL, 32'h0000_0003, 1'b0);
    wr(REG_CTRL, 32'h0000_0000);
    $display("test registers done");
    vb = {8'h07};
    cmd(TYPE_QUE, 8'h53, 16'h4244, vb, 1'b0);
    exp_resp(8'h53, 1'b1, 32'h0000_0007, 1'b1);
    cmd(TYPE_QUE, 8'h17, 16'h4244, nv, 1'b0);
    exp_resp(8'h17, 1'b1, 32'h0000_0000, 1'b1);
    rd(REG_STATUS, 32'h0040_0000, 1'b0);
    napp = 0;
    cmd(TYPE_QUE, 8'h21, APPLY_CMD, nv, 1'b0);
    chk(napp, 1);
    cmd(TYPE_QUE, 8'h22, 16'h4244, nv, 1'b0);
    exp_resp(8'h22, 1'b1, 32'h0000_0007, 1'b1);
    $display("test queued done");
    for (int k = 0; k < 3; k++) begin
      vb = {8'(k)};
      cmd(TYPE_QUE, 8'h40 + 8'(k), 16'h4244, vb, 1'b0);
      vb.delete();
      repeat ($urandom_range(1, 4)) vb.push_back(8'($urandom));
      v = fold(vb);
      napp = 0;
      cmd(TYPE_IMM, 8'h60 + 8'(k), 16'h5450, vb, 1'b0);
      exp_resp(8'h60 + 8'(k), 1'b1, v, 1'b1);
      chk(napp, 1);
      cmd(TYPE_QUE, 8'h70 + 8'(k), 16'h5450, nv, 1'b0);
      exp_resp(8'h70 + 8'(k), 1'b1, v, 1'b1);
      cmd(TYPE_QUE, 8'h80 + 8'(k), 16'h4244, nv, 1'b0);
      exp_resp(8'h80 + 8'(k), 1'b1, 32'(k), 1'b1);
    end
    $display("test immediate done");
    vb = {8'h05};
    cmd(TYPE_QUE, 8'h00, 16'h4244, vb, 1'b0);
    chk(rq.size(), 0);
    cmd(TYPE_IMM, 8'h00, 16'h5450, nv, 1'b0);
    chk(rq.size(), 0);
    cmd(TYPE_QUE, 8'h01, 16'h4244, nv, 1'b0);
    exp_resp(8'h01, 1'b1, 32'h0000_0005, 1'b1);
    vb = {8'h66};
    cmd(TYPE_QUE, 8'h33, 16'h4244, vb, 1'b1);
    chk(rq.size(), 0);
    rd(REG_ERRCNT, 32'h0000_0001, 1'b0);
    rd(REG_STATUS, 32'h0000_0000, 1'b0);
    vb = {8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
    cmd(TYPE_QUE, 8'h34, 16'h4244, vb, 1'b0);
    exp_resp(8'h34, 1'b0, 32'h0000_0000, 1'b0);
    rd(REG_STATUS, 32'h0000_0000, 1'b0);
    $display("test faults done");
    i_aprfp_host_model.put(8'h55, 1);
    i_aprfp_host_model.put(8'h00, 1);
    cmd(TYPE_QUE, 8'h35, 16'h4244, nv, 1'b0);
    exp_resp(8'h35, 1'b1, 32'h0000_0005, 1'b1);
    // Bytes offered while the clock enable is low must leave no trace.
    ce <= 1'b0;
    i_aprfp_host_model.put(START_BYTE, 1);
    i_aprfp_host_model.put(8'h00, 1);
    ce <= 1'b1;
    cmd(TYPE_QUE, 8'h36, 16'h4244, nv, 1'b0);
    exp_resp(8'h36, 1'b1, 32'h0000_0005, 1'b1);
    wr(REG_CTRL, 32'h0000_0001);
    esc_on <= 1'b1;
    @(posedge ref_clk);
    i_aprfp_host_model.put(START_BYTE, 1);
    i_aprfp_host_model.put(8'h00, 1);
    vb = {START_BYTE, ESC_BYTE};
    cmd(TYPE_QUE, 8'h7e, 16'h4244, vb, 1'b0);
    exp_resp(8'h7e, 1'b1, 32'h0000_7e7d, 1'b1);
    wr(REG_CTRL, 32'h0000_0000);
    esc_on <= 1'b0;
    $display("test resync done");
    for (int k = 0; k < 12; k++) begin
      d = (k % 3 == 0) ? BCAST_ADDR : {$urandom, $urandom};
      id = (k == 5) ? 8'h00 : 8'($urandom_range(1, 255));
      opt = 8'($urandom_range(0, 7)) & 8'h05;
      n = $urandom_range(0, 8);
      wr(REG_CTRL, {30'h0, k[2], 1'b0});
      b = {TYPE_TX, id};
      for (int j = 7; j >= 0; j--) b.push_back(d[j*8+:8]);
      b.push_back(opt);
      repeat (n) b.push_back(8'($urandom));
      b = b[4:$];
      cmd(TYPE_TX, id, {d[63:56], d[55:48]}, b, 1'b0);
      chk(tq.size(), 1);
      if (tq.size() > 0) begin
        chk(tq[0].dest, d);
        chk(tq[0].broadcast, d == 64'h0000_0000_0000_ffff);
        chk(tq[0].no_ack, opt[0]);
        chk(tq[0].bcast_pan, opt[2] & k[2]);
        chk(tq[0].len, n);
      end
      chk(rq.size(), (id != 8'h00) ? 1 : 0);
      if (rq.size() > 0) begin
        chk(rq[0].rtype, RESP_TX);
        chk(rq[0].id, id);
      end
    end
    rd(REG_FRMCNT, 32'h0000_0023, 1'b0);
    $display("test transmit done");
    finish_test();
  end
endmodule
